// >>> core/vls_pkg.sv
package vls_pkg;

	////////////////////////////////////////////////////////////////
	// Timing
	localparam int VLS_CLK_NS = 20;
	localparam int VLS_TICK_MS = 1;
	localparam int VLS_NS_PER_MS = 1_000_000;
	localparam int VLS_TICK_CYCLES = (VLS_TICK_MS * VLS_NS_PER_MS + VLS_CLK_NS - 1) / VLS_CLK_NS;
	localparam logic [15:0] VLS_DWELL_MIN_MS = 16'h000A;
	localparam logic [15:0] VLS_DWELL_MAX_MS = 16'hFDE8;

	////////////////////////////////////////////////////////////////
	// List geometry
	localparam logic [4:0] VLS_LIST_DEPTH = 5'h14;
	localparam logic [5:0] VLS_LIST_BASE_WORD = 6'h10;

	////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] VLS_OFF_CTRL = 8'h00;
	localparam logic [7:0] VLS_OFF_CMD = 8'h04;
	localparam logic [7:0] VLS_OFF_COUNT = 8'h08;
	localparam logic [7:0] VLS_OFF_LEVEL = 8'h0C;
	localparam logic [7:0] VLS_OFF_OPER = 8'h10;
	localparam logic [7:0] VLS_OFF_QCOND = 8'h14;
	localparam logic [7:0] VLS_OFF_QEVENT = 8'h18;
	localparam logic [7:0] VLS_OFF_QENABLE = 8'h1C;
	localparam logic [7:0] VLS_OFF_QPTRANS = 8'h20;
	localparam logic [7:0] VLS_OFF_SRENABLE = 8'h24;
	localparam logic [7:0] VLS_OFF_STB = 8'h28;
	localparam logic [7:0] VLS_OFF_SETP = 8'h2C;
	localparam logic [7:0] VLS_OFF_LIST = 8'h40;

	////////////////////////////////////////////////////////////////
	// Field positions
	localparam int VLS_CMD_ARM = 0;
	localparam int VLS_CMD_TRIG = 1;
	localparam int VLS_CMD_ABORT = 2;
	localparam int VLS_CMD_CLEAR = 3;
	localparam int VLS_OPER_RUN_BIT = 4;
	localparam int VLS_OPER_WTG_BIT = 5;
	localparam int VLS_QUES_OVERCUR_BIT = 1;
	localparam int VLS_STB_QUES_BIT = 3;
	localparam int VLS_STB_RQS_BIT = 6;

	////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [6:0] VLS_CTRL_RST = 7'h00;
	localparam logic [7:0] VLS_REP_RST = 8'h01;
	localparam logic [7:0] VLS_QPTR_RST = 8'hFF;

	typedef enum logic [1:0] {
		st_idle,
		st_armed,
		st_run,
		st_trip
	} vls_state_e;

	typedef struct packed {
		logic output_on;
		logic prot_en;
		logic step_trig_en;
		logic ext_trig_sel;
		logic repeat_inf;
		logic dwell_pace;
		logic list_mode;
	} vls_ctrl_s;

	typedef struct packed {
		logic [15:0] dwell_ms;
		logic [15:0] level;
	} vls_entry_s;

	function automatic logic [31:0] vls_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic [15:0] vls_clamp_dwell(input logic [15:0] ms);
		if (ms < VLS_DWELL_MIN_MS) begin
			return VLS_DWELL_MIN_MS;
		end
		if (ms > VLS_DWELL_MAX_MS) begin
			return VLS_DWELL_MAX_MS;
		end
		return ms;
	endfunction

endpackage

// >>> core/vls_sync2.sv
`timescale 1ns/1ns
module vls_sync2 #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} vls_sync2_s;

	vls_sync2_s r;
	vls_sync2_s n;

	// First stage feeds only the second
	always_comb begin
		n.s1 = din;
		n.s2 = r.s1;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign dout = r.s2;

endmodule

// >>> core/vls_dwell_timer.sv
`timescale 1ns/1ns
module vls_dwell_timer #(
	parameter int TICK_CYCLES = vls_pkg::VLS_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic stop,
	input wire logic [15:0] dwell_ms,
	output logic expire
);

	typedef struct packed {
		logic run;
		logic [15:0] ms;
		logic [15:0] tick;
		logic exp;
	} vls_timer_s;

	vls_timer_s r;
	vls_timer_s n;

	always_comb begin
		n = r;
		n.exp = 1'b0;
		if (load) begin
			n.run = 1'b1;
			n.ms = dwell_ms;
			n.tick = 16'(TICK_CYCLES - 1);
		end else if (stop) begin
			n.run = 1'b0;
		end else if (r.run) begin
			if (r.tick == 16'h0000) begin
				n.tick = 16'(TICK_CYCLES - 1);
				if (r.ms == 16'h0001) begin
					n.run = 1'b0;
					n.exp = 1'b1;
				end else begin
					n.ms = r.ms - 16'h0001;
				end
			end else begin
				n.tick = r.tick - 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign expire = r.exp;

	property p_min_dwell;
		@(posedge sys_clk) disable iff (sys_rst)
		load |=> !expire [*8];
	endproperty
	a_min_dwell: assert property (p_min_dwell) else $error("dwell ended too early");

endmodule

// >>> core/vls_core.sv
`timescale 1ns/1ns
module vls_core #(
	parameter int TICK_CYCLES = vls_pkg::VLS_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic constant_current_state,
	input wire logic ext_trig_in,
	input wire logic backplane_trig_in,
	output logic [15:0] setpoint_out,
	output logic output_enable,
	output logic step_trig_out,
	output logic wait_trig,
	output logic srq
);

	typedef struct packed {
		vls_pkg::vls_state_e st;
		vls_pkg::vls_ctrl_s ctrl;
		logic [4:0] len;
		logic [7:0] rep;
		logic [7:0] pass;
		logic [4:0] idx;
		logic [15:0] setp;
		logic [15:0] level;
		logic trip;
		logic oen;
		logic [7:0] qcond;
		logic [7:0] qev;
		logic [7:0] qen;
		logic [7:0] qptr;
		logic [7:0] sre;
		logic srq;
		logic step;
		logic [1:0] ext_d;
		logic ack;
		logic [31:0] rdata;
		vls_pkg::vls_entry_s [19:0] list;
	} vls_core_s;

	vls_core_s r;
	vls_core_s n;

	logic curr_lim_s;
	logic [1:0] ext_s;
	logic take;
	logic wr_go;
	logic rd_go;
	logic [3:0] cmd;
	logic [4:0] li;
	logic li_ok;
	logic ext_evt;
	logic trig_evt;
	logic trip_set;
	logic expire;
	logic adv;
	logic [7:0] stb;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers and dwell timer
	vls_sync2 #(.W(1)) u_curr_lim_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.din(constant_current_state),
		.dout(curr_lim_s)
	);

	vls_sync2 #(.W(2)) u_trig_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.din({backplane_trig_in, ext_trig_in}),
		.dout(ext_s)
	);

	vls_dwell_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.load(n.step),
		.stop(n.st != vls_pkg::st_run),
		.dwell_ms(vls_pkg::vls_clamp_dwell(r.list[n.idx].dwell_ms)),
		.expire(expire)
	);

	////////////////////////////////////////////////////////////////
	// Bus decode
	assign take = (read | write) & ~r.ack;
	assign waitrequest = (read | write) & ~r.ack;
	assign wr_go = write & r.ack;
	assign rd_go = read & r.ack;
	assign li = 5'(address[7:2] - vls_pkg::VLS_LIST_BASE_WORD);
	assign li_ok = (address >= vls_pkg::VLS_OFF_LIST) && (address[1:0] == 2'b00)
		&& (li < vls_pkg::VLS_LIST_DEPTH);
	assign cmd = (wr_go && address == vls_pkg::VLS_OFF_CMD && byteenable[0]) ?
		writedata[3:0] : 4'h0;

	////////////////////////////////////////////////////////////////
	// Trigger and trip events
	assign ext_evt = |(ext_s & ~r.ext_d);
	assign trig_evt = r.ctrl.ext_trig_sel ? ext_evt : cmd[vls_pkg::VLS_CMD_TRIG];
	assign trip_set = r.ctrl.prot_en & curr_lim_s & ~r.trip;
	assign adv = r.ctrl.dwell_pace ? expire : trig_evt;
	assign stb = {1'b0, r.srq, 5'h00, 1'b0} | ({7'h00, |(r.qev & r.qen)} << vls_pkg::VLS_STB_QUES_BIT);

	function automatic logic [31:0] rd_word(input vls_core_s s, input logic [7:0] a,
		input logic [7:0] sb, input logic [4:0] i, input logic ok);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			vls_pkg::VLS_OFF_CTRL: w = {25'h000_0000, s.ctrl};
			vls_pkg::VLS_OFF_COUNT: w = {16'h0000, s.rep, 3'h0, s.len};
			vls_pkg::VLS_OFF_LEVEL: w = {16'h0000, s.level};
			vls_pkg::VLS_OFF_OPER: begin
				w[vls_pkg::VLS_OPER_WTG_BIT] = (s.st == vls_pkg::st_armed);
				w[vls_pkg::VLS_OPER_RUN_BIT] = (s.st == vls_pkg::st_run);
			end
			vls_pkg::VLS_OFF_QCOND: w = {24'h00_0000, s.qcond};
			vls_pkg::VLS_OFF_QEVENT: w = {24'h00_0000, s.qev};
			vls_pkg::VLS_OFF_QENABLE: w = {24'h00_0000, s.qen};
			vls_pkg::VLS_OFF_QPTRANS: w = {24'h00_0000, s.qptr};
			vls_pkg::VLS_OFF_SRENABLE: w = {24'h00_0000, s.sre};
			vls_pkg::VLS_OFF_STB: w = {24'h00_0000, sb};
			vls_pkg::VLS_OFF_SETP: w = {11'h000, s.idx, s.setp};
			default: begin
				if (ok) begin
					w = s.list[i];
				end
			end
		endcase
		return w;
	endfunction

	////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		n = r;
		n.step = 1'b0;
		n.ack = take;
		n.ext_d = ext_s;
		if (take) begin
			n.rdata = rd_word(r, address, stb, li, li_ok);
		end

		// Register writes land on the cycle waitrequest is low
		if (wr_go) begin
			case (address)
				vls_pkg::VLS_OFF_CTRL: begin
					n.ctrl = vls_pkg::vls_ctrl_s'(vls_pkg::vls_merge({25'h000_0000, r.ctrl},
						writedata, byteenable) & 32'h0000_007F);
				end
				vls_pkg::VLS_OFF_COUNT: begin
					if (byteenable[0]) begin
						n.len = (writedata[4:0] == 5'h00) ? 5'h01 :
							(writedata[4:0] > vls_pkg::VLS_LIST_DEPTH) ?
							vls_pkg::VLS_LIST_DEPTH : writedata[4:0];
					end
					if (byteenable[1]) begin
						n.rep = (writedata[15:8] == 8'h00) ? 8'h01 : writedata[15:8];
					end
				end
				vls_pkg::VLS_OFF_LEVEL: begin
					n.level = 16'(vls_pkg::vls_merge({16'h0000, r.level}, writedata, byteenable));
				end
				vls_pkg::VLS_OFF_QENABLE: begin
					if (byteenable[0]) begin
						n.qen = writedata[7:0];
					end
				end
				vls_pkg::VLS_OFF_QPTRANS: begin
					if (byteenable[0]) begin
						n.qptr = writedata[7:0];
					end
				end
				vls_pkg::VLS_OFF_SRENABLE: begin
					if (byteenable[0]) begin
						n.sre = writedata[7:0];
					end
				end
				default: begin
					if (li_ok) begin
						n.list[li] = vls_pkg::vls_merge(r.list[li], writedata, byteenable);
					end
				end
			endcase
		end

		// Sequencer
		unique case (r.st)
			vls_pkg::st_idle: begin
				if (cmd[vls_pkg::VLS_CMD_ARM] && r.ctrl.list_mode) begin
					n.st = vls_pkg::st_armed;
				end
			end
			vls_pkg::st_armed: begin
				if (cmd[vls_pkg::VLS_CMD_ABORT] || !r.ctrl.list_mode) begin
					n.st = vls_pkg::st_idle;
				end else if (trig_evt) begin
					n.st = vls_pkg::st_run;
					n.idx = 5'h00;
					n.pass = 8'h00;
					n.setp = r.list[0].level;
					n.step = 1'b1;
				end
			end
			vls_pkg::st_run: begin
				if (cmd[vls_pkg::VLS_CMD_ABORT] || !r.ctrl.list_mode) begin
					n.st = vls_pkg::st_idle;
				end else if (adv) begin
					if (r.idx == r.len - 5'h01) begin
						if (r.ctrl.repeat_inf || (r.pass + 8'h01 < r.rep)) begin
							n.idx = 5'h00;
							n.setp = r.list[0].level;
							n.step = 1'b1;
							if (!r.ctrl.repeat_inf) begin
								n.pass = r.pass + 8'h01;
							end
						end else begin
							n.st = vls_pkg::st_idle;
						end
					end else begin
						n.idx = r.idx + 5'h01;
						n.setp = r.list[r.idx + 5'h01].level;
						n.step = 1'b1;
					end
				end
			end
			vls_pkg::st_trip: begin
				if (cmd[vls_pkg::VLS_CMD_CLEAR]) begin
					n.st = vls_pkg::st_idle;
					n.trip = 1'b0;
					n.ctrl.output_on = 1'b0;
				end
			end
		endcase

		if (!n.ctrl.list_mode) begin
			n.setp = n.level;
		end

		// Trip beats any state change or step pulse in the same cycle
		if (trip_set) begin
			n.trip = 1'b1;
			n.st = vls_pkg::st_trip;
			n.step = 1'b0;
		end
		n.oen = n.ctrl.output_on & ~n.trip;

		// Questionable group, set wins over read-clear
		n.qcond = 8'h00;
		n.qcond[vls_pkg::VLS_QUES_OVERCUR_BIT] = n.trip;
		if (rd_go && address == vls_pkg::VLS_OFF_QEVENT) begin
			n.qev = 8'h00;
		end
		n.qev = n.qev | (n.qcond & ~r.qcond & r.qptr);
		n.srq = (|(n.qev & n.qen)) & n.sre[vls_pkg::VLS_STB_QUES_BIT];
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
			r.st <= vls_pkg::st_idle;
			r.ctrl <= vls_pkg::VLS_CTRL_RST;
			r.len <= vls_pkg::VLS_LIST_DEPTH;
			r.rep <= vls_pkg::VLS_REP_RST;
			r.qptr <= vls_pkg::VLS_QPTR_RST;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign readdata = r.rdata;
	assign setpoint_out = r.setp;
	assign output_enable = r.oen;
	assign step_trig_out = r.step & r.ctrl.step_trig_en;
	assign wait_trig = (r.st == vls_pkg::st_armed);
	assign srq = r.srq;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_step_at(logic [4:0] i);
		r.step && r.st == vls_pkg::st_run && r.idx == i;
	endsequence

	property p_trip_off;
		trip_set |=> !output_enable && r.trip ##1 !output_enable;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("trip left output on");

	property p_halt;
		r.trip && !cmd[vls_pkg::VLS_CMD_CLEAR] |=> r.st == vls_pkg::st_trip && !r.step && $stable(r.setp);
	endproperty
	a_halt: assert property (p_halt) else $error("list moved while tripped");

	property p_srq;
		$rose(r.trip) && r.qen[1] && r.sre[3] && $past(r.qptr[1]) |-> srq && r.qev[1] && r.qcond[1];
	endproperty
	a_srq: assert property (p_srq) else $error("trip raised no request");

	property p_no_trip;
		!r.ctrl.prot_en && !r.trip |=> !r.trip;
	endproperty
	a_no_trip: assert property (p_no_trip) else $error("trip without protection");

	property p_start;
		wait_trig && trig_evt && !trip_set && !cmd[vls_pkg::VLS_CMD_ABORT] && r.ctrl.list_mode
			|=> s_step_at(5'h00) and (setpoint_out == r.list[0].level);
	endproperty
	a_start: assert property (p_start) else $error("trigger did not start list");

	property p_ext_only;
		wait_trig && r.ctrl.ext_trig_sel && !ext_evt && !trip_set |=> wait_trig || r.st == vls_pkg::st_idle;
	endproperty
	a_ext_only: assert property (p_ext_only) else $error("start without selected trigger");

	property p_step;
		r.st == vls_pkg::st_run && adv && r.idx != r.len - 5'h01 && !trip_set
			&& !cmd[vls_pkg::VLS_CMD_ABORT] && r.ctrl.list_mode
			|=> s_step_at($past(r.idx) + 5'h01) ##0 (step_trig_out == r.ctrl.step_trig_en);
	endproperty
	a_step: assert property (p_step) else $error("list did not step");

	property p_wrap;
		r.st == vls_pkg::st_run && adv && r.idx == r.len - 5'h01 && r.ctrl.repeat_inf
			&& !trip_set && !cmd[vls_pkg::VLS_CMD_ABORT] && r.ctrl.list_mode |=> s_step_at(5'h00);
	endproperty
	a_wrap: assert property (p_wrap) else $error("infinite list did not wrap");

	property p_wtg;
		wait_trig && !trig_evt && !trip_set && !cmd[vls_pkg::VLS_CMD_ABORT] && r.ctrl.list_mode
			|=> wait_trig;
	endproperty
	a_wtg: assert property (p_wtg) else $error("armed state lost");

endmodule

// >>> bench/vls_load_model.sv
`timescale 1ns/1ns
module vls_load_model (
	input wire logic sys_clk,
	input wire logic output_enable,
	input wire logic short_fault,
	input wire logic open_fault,
	input wire logic fire_ext,
	input wire logic fire_bp,
	output logic constant_current_state,
	output logic ext_trig_in,
	output logic backplane_trig_in
);
	logic [2:0] ext_cnt = 3'h0;
	logic [2:0] bp_cnt = 3'h0;

	////////////////////////////////////////////////////////////////
	// Shorted load pulls a live output into current limit; open load never does
	assign constant_current_state = output_enable & short_fault & ~open_fault;

	////////////////////////////////////////////////////////////////
	// Trigger pins stretched so the synchroniser sees them
	always_ff @(posedge sys_clk) begin
		ext_cnt <= fire_ext ? 3'h4 : ext_cnt - {2'h0, ext_cnt != 3'h0};
		bp_cnt <= fire_bp ? 3'h4 : bp_cnt - {2'h0, bp_cnt != 3'h0};
	end
	assign ext_trig_in = ext_cnt != 3'h0;
	assign backplane_trig_in = bp_cnt != 3'h0;
endmodule

// >>> bench/vls_core_tb.sv
`timescale 1ns/1ns
module vls_core_tb;
	logic sys_clk, sys_rst, read, write, waitrequest, curr_lim, ext_pin, bp_pin;
	logic output_enable, step_trig_out, wait_trig, srq;
	logic short_fault, open_fault, fire_ext, fire_bp;
	logic [7:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, q;
	logic [15:0] setpoint_out, dw, hold;
	logic [15:0] lv [3];
	int num_errors, check_count, seed, n, lim;

	// Clocks per dwell millisecond, shortened for simulation
	localparam int TICK = 5;

	// Expected clocks of one dwell, before the extra expire cycle
	function automatic int dwell_cycles(input logic [15:0] ms);
		return ms * TICK;
	endfunction

	// Expected setpoint register word
	function automatic logic [31:0] setp_word(input logic [4:0] i, input logic [15:0] l);
		return {11'h000, i, l};
	endfunction

	vls_core #(.TICK_CYCLES(TICK)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .address(address),
		.read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .constant_current_state(curr_lim),
		.ext_trig_in(ext_pin), .backplane_trig_in(bp_pin), .setpoint_out(setpoint_out),
		.output_enable(output_enable), .step_trig_out(step_trig_out),
		.wait_trig(wait_trig), .srq(srq));
	vls_load_model load (.sys_clk(sys_clk), .output_enable(output_enable),
		.short_fault(short_fault), .open_fault(open_fault), .fire_ext(fire_ext),
		.fire_bp(fire_bp), .constant_current_state(curr_lim), .ext_trig_in(ext_pin),
		.backplane_trig_in(bp_pin));

	initial begin
		sys_clk = 1'h0;
		forever #10 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////
	// Checking and bus tasks
	task automatic results;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		check_count++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge sys_clk);
		end while (waitrequest !== 1'h0);
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask

	// Counts cycles until the next step pulse, giving up at lm
	task automatic wait_step(input int lm);
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (step_trig_out !== 1'h1 && n < lm);
	endtask

	task automatic fire(input logic use_bp);
		@(posedge sys_clk);
		fire_bp <= use_bp;
		fire_ext <= ~use_bp;
		@(posedge sys_clk);
		fire_bp <= 1'h0;
		fire_ext <= 1'h0;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{read, write, short_fault, open_fault, fire_ext, fire_bp} = 6'h00;
		address = 8'h00;
		byteenable = 4'hf;
		writedata = 32'h0000_0000;
		sys_rst = 1'h1;
		seed = 28;
		for (int i = 0; i < 3; i++) begin
			lv[i] = 16'($random(seed));
		end
		dw = 16'h000a + {14'h0000, 2'($random(seed))};
		lim = dwell_cycles(dw) + 20;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'h0;
		rdc("ctrl_rst", 8'h00, 32'h0000_0000);
		rdc("count_rst", 8'h08, 32'h0000_0114);
		rdc("qptrans_rst", 8'h20, 32'h0000_00ff);
		wr(8'h3c, 32'hffff_ffff);
		rdc("unmapped", 8'h3c, 32'h0000_0000);
		wr(8'h0c, {16'h0000, lv[2]});
		wr(8'h00, 32'h0000_0040);
		chk("level_setp", {16'h0000, lv[2]}, {16'h0000, setpoint_out});
		for (int i = 0; i < 3; i++) begin
			wr(8'h40 + 8'(i * 4), {dw, lv[i]});
		end
		wr(8'h08, 32'h0000_0103);
		wr(8'h1c, 32'h0000_0002);
		wr(8'h24, 32'h0000_0008);
		wr(8'h00, 32'h0000_0077);
		wr(8'h04, 32'h0000_0001);
		rdc("oper_armed", 8'h10, 32'h0000_0020);
		chk("wait_trig", 32'h0000_0001, {31'h0, wait_trig});
		wr(8'h04, 32'h0000_0002);
		// First step pulse stands in the cycle right after the trigger write
		#1;
		chk("start_pulse", 32'h0000_0001, {31'h0, step_trig_out});
		for (int k = 0; k < 7; k++) begin
			if (k == 1) begin
				open_fault <= 1'h1;
			end
			if (k > 0) begin
				wait_step(lim);
				chk_rng("dwell", dwell_cycles(dw), dwell_cycles(dw) + 2, n);
			end
			chk("list_setp", {16'h0000, lv[k % 3]}, {16'h0000, setpoint_out});
		end
		chk("open_oe", 32'h0000_0001, {31'h0, output_enable});
		chk("open_srq", 32'h0000_0000, {31'h0, srq});
		@(posedge sys_clk);
		open_fault <= 1'h0;
		short_fault <= 1'h1;
		n = 0;
		while (output_enable !== 1'h0 && n < 10) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk_rng("trip_delay", 0, 6, n);
		chk("srq", 32'h0000_0001, {31'h0, srq});
		hold = setpoint_out;
		wait_step(lim * 2);
		chk("halt_steps", lim * 2, n);
		chk("halt_setp", {16'h0000, hold}, {16'h0000, setpoint_out});
		rdc("qcond", 8'h14, 32'h0000_0002);
		rdc("stb", 8'h28, 32'h0000_0048);
		rdc("qevent", 8'h18, 32'h0000_0002);
		rdc("qevent_clr", 8'h18, 32'h0000_0000);
		short_fault <= 1'h0;
		wr(8'h04, 32'h0000_0001);
		rdc("oper_tripped", 8'h10, 32'h0000_0000);
		chk("trip_oe", 32'h0000_0000, {31'h0, output_enable});
		wr(8'h04, 32'h0000_0008);
		wr(8'h08, 32'h0000_0102);
		wr(8'h00, 32'h0000_005b);
		wr(8'h04, 32'h0000_0001);
		wr(8'h04, 32'h0000_0002);
		rdc("oper_ext", 8'h10, 32'h0000_0020);
		fire(1'h1);
		wait_step(lim);
		chk("bp_setp0", {16'h0000, lv[0]}, {16'h0000, setpoint_out});
		wait_step(lim);
		chk("bp_setp1", {16'h0000, lv[1]}, {16'h0000, setpoint_out});
		wait_step(lim * 2);
		chk("finite_end", lim * 2, n);
		rdc("oper_done", 8'h10, 32'h0000_0000);
		chk("reprog_oe", 32'h0000_0001, {31'h0, output_enable});
		wr(8'h04, 32'h0000_0001);
		fire(1'h0);
		wait_step(lim);
		chk("ext_setp0", {16'h0000, lv[0]}, {16'h0000, setpoint_out});
		// Dwell steps with the step pulse option off
		wr(8'h00, 32'h0000_0043);
		wait_step(lim);
		chk("step_pulse_off", lim, n);
		rdc("setp_idx", 8'h2c, setp_word(5'h01, lv[1]));
		// Trigger paced list, one bus trigger per step
		wr(8'h04, 32'h0000_0004);
		wr(8'h00, 32'h0000_0041);
		wr(8'h04, 32'h0000_0001);
		wr(8'h04, 32'h0000_0002);
		wr(8'h04, 32'h0000_0002);
		rdc("trig_paced", 8'h2c, setp_word(5'h01, lv[1]));
		wr(8'h04, 32'h0000_0002);
		rdc("trig_end", 8'h10, 32'h0000_0000);
		results();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		results();
	end
endmodule
